// file: design/pdme_pkg.sv
package pdme_pkg;
	// Bus widths
	localparam int PDME_AW = 12;
	localparam int PDME_DW = 32;
	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [PDME_AW-1:0] paddr;
		logic [PDME_DW-1:0] pwdata;
	} pdme_apb_req_t;
	// APB answer of the slave
	typedef struct packed {
		logic pready;
		logic [PDME_DW-1:0] prdata;
		logic pslverr;
	} pdme_apb_rsp_t;
	// One serial line bit with its strobe
	typedef struct packed {
		logic bit_val;
		logic strobe;
	} pdme_bit_t;
	// Register indices; byte address is four times the index
	localparam logic [PDME_AW-3:0] PDME_RX_IDX = 10'h055;
	localparam logic [PDME_AW-3:0] PDME_TX_IDX = 10'h059;
	localparam logic [PDME_AW-3:0] PDME_STAT_IDX = 10'h060;
	localparam logic [PDME_AW-3:0] PDME_CLR_IDX = 10'h061;
	localparam logic [PDME_AW-3:0] PDME_EN_IDX = 10'h062;
	// Fields of the two monitor registers
	localparam int PDME_B_DC_EN = 0;
	localparam int PDME_B_ZR_EN = 1;
	localparam int PDME_B_DC_FLAG = 2;
	localparam int PDME_B_ZR_FLAG = 3;
	localparam int PDME_B_DV = 4;
	localparam int PDME_B_FILL_FLAG = 5;
	localparam int PDME_B_FILL_EN = 6;
	localparam int PDME_B_FILL_IRQ_EN = 7;
	// Fields of the summary status, clear and enable registers
	localparam int PDME_S_RX_DC = 0;
	localparam int PDME_S_RX_ZR = 1;
	localparam int PDME_S_TX_DC = 2;
	localparam int PDME_S_TX_ZR = 3;
	localparam int PDME_S_FILL = 4;
	// Density rule and zero run
	localparam int PDME_MAX_N = 23;
	localparam logic [4:0] PDME_ZRUN_LEN = 5'h10;
	// Reset values
	localparam logic PDME_EN_RST = 1'b0;
	localparam logic PDME_IRQ_N_RST = 1'b1;
endpackage

// file: design/pdme_top.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
// What this block does
// (R1) Density change raises irq when enabled
// (R2) Sixteen zeros raise irq when enabled
// (R3) Density change sets flag; read clears
// (R4) Sixteen zeros set flag; read clears
// (R5) Flags latch regardless of irq enables
// (R6) Live violation bit, no latching
// (R7) Transmit live bit zero while filling
// (R8) Fill enabled inserts ones on violation
// (R9) Fill off passes data, reports density
// (R10) Insertion sets flag; read clears it
// (R11) Fill irq enable gates insertion irq
// (R12) Filling holds transmit flags at zero
// (R13) Transmit density irq only without fill irq
// (R14) Enables and fill reset to zero
// (R15) Irq low while enabled flag set
// (R16) Ones density rule, parameterised checker
module pdme_top import pdme_pkg::*; #(
	parameter int MAX_N = PDME_MAX_N
) (
	input wire logic clk,
	input wire logic rst,
	input wire pdme_apb_req_t apb_req,
	output pdme_apb_rsp_t apb_rsp,
	input wire pdme_bit_t rx_in,
	input wire pdme_bit_t tx_in,
	output pdme_bit_t tx_out,
	output logic irq_n_out
);
	// Window of the longest density check
	localparam int WIN = 8 * (MAX_N + 1);

	// Refuse windows the history cannot serve, at elaboration
	if (MAX_N < 1 || MAX_N > 31) begin : g_bad_max_n
		$error("MAX_N out of range");
	end

	// Whole state of the block
	typedef struct packed {
		logic [WIN-1:0] rx_hist; // Received bits, newest at bit 0
		logic [WIN-1:0] tx_hist; // Sent bits, newest at bit 0
		logic [4:0] rx_zrun; // Receive zero run, saturating
		logic [4:0] tx_zrun; // Transmit zero run, saturating
		logic rx_dv; // Receive live violation
		logic tx_dv; // Transmit live violation
		logic rx_dc_flag;
		logic rx_zr_flag;
		logic tx_dc_flag;
		logic tx_zr_flag;
		logic fill_flag;
		logic rx_dc_en;
		logic rx_zr_en;
		logic tx_dc_en;
		logic tx_zr_en;
		logic fill_en;
		logic fill_irq_en;
		pdme_bit_t tx_out; // Registered line output
		pdme_apb_rsp_t rsp; // Registered bus answer
		logic irq_n; // Registered interrupt request
	} pdme_state_t;

	pdme_state_t s_r; // Current state
	pdme_state_t s_nxt; // Next state

	// Density rule: at least n ones in every 8(n+1) bits
	function automatic logic density_bad(input logic [WIN-1:0] h);
		int ones;
		logic bad;
		bad = 1'b0;
		for (int n = 1; n <= MAX_N; n++) begin
			ones = 0;
			for (int i = 0; i < WIN; i++) begin
				if (i < 8 * (n + 1)) begin
					ones = ones + int'(h[i]);
				end
			end
			if (ones < n) begin
				bad = 1'b1;
			end
		end
		return bad;
	endfunction

	// Zero run count, held at its limit
	function automatic logic [4:0] zrun_step(input logic [4:0] z, input logic b);
		if (b) begin
			return 5'h00;
		end
		if (z == PDME_ZRUN_LEN) begin
			return z;
		end
		return 5'(z + 5'h01);
	endfunction

	// Word address match
	function automatic logic hit(input logic [PDME_AW-1:0] a, input logic [PDME_AW-3:0] idx);
		return a[PDME_AW-1:2] == idx;
	endfunction

	// Event strobes of this cycle
	logic rx_dc_evt;
	logic rx_zr_evt;
	logic tx_dc_evt;
	logic tx_zr_evt;
	logic fill_evt;
	// Receive and transmit working values
	logic [WIN-1:0] rx_new;
	logic [WIN-1:0] tx_raw;
	logic tx_bad;
	logic tx_bit;
	// Bus working values
	logic acc;
	logic first;
	logic done;
	logic mapped;
	logic [PDME_DW-1:0] rd_val;
	logic [PDME_DW-1:0] wd;
	// Clear masks from reads and from the clear register
	logic clr_rx_dc;
	logic clr_rx_zr;
	logic clr_tx_dc;
	logic clr_tx_zr;
	logic clr_fill;
	logic irq;

	// Next state of stream, bus and interrupt logic
	always_comb begin
		s_nxt = s_r;
		rx_dc_evt = 1'b0;
		rx_zr_evt = 1'b0;
		tx_dc_evt = 1'b0;
		tx_zr_evt = 1'b0;
		// Receive monitor only reports
		rx_new = {s_r.rx_hist[WIN-2:0], rx_in.bit_val};
		if (rx_in.strobe) begin
			s_nxt.rx_hist = rx_new;
			s_nxt.rx_zrun = zrun_step(s_r.rx_zrun, rx_in.bit_val);
			s_nxt.rx_dv = density_bad(rx_new); // see (R6) (R16)
			rx_dc_evt = s_nxt.rx_dv != s_r.rx_dv; // see (R3)
			rx_zr_evt = s_nxt.rx_zrun == PDME_ZRUN_LEN && s_r.rx_zrun != PDME_ZRUN_LEN; // see (R4)
		end
		// Transmit enforcer
		tx_raw = {s_r.tx_hist[WIN-2:0], tx_in.bit_val};
		tx_bad = density_bad(tx_raw);
		fill_evt = s_r.fill_en & tx_in.strobe & tx_bad & ~tx_in.bit_val; // see (R8)
		tx_bit = fill_evt ? 1'b1 : tx_in.bit_val; // see (R8) (R9)
		s_nxt.tx_out.bit_val = tx_bit;
		s_nxt.tx_out.strobe = tx_in.strobe;
		if (tx_in.strobe) begin
			s_nxt.tx_hist = {s_r.tx_hist[WIN-2:0], tx_bit};
			s_nxt.tx_zrun = zrun_step(s_r.tx_zrun, tx_bit);
			if (!s_r.fill_en) begin
				// Passthrough reports density like the monitor
				s_nxt.tx_dv = tx_bad; // see (R9)
				tx_dc_evt = tx_bad != s_r.tx_dv; // see (R9)
				tx_zr_evt = s_nxt.tx_zrun == PDME_ZRUN_LEN && s_r.tx_zrun != PDME_ZRUN_LEN;
			end
		end
		if (s_r.fill_en) begin
			s_nxt.tx_dv = 1'b0; // see (R7)
		end
		// APB slave: one wait state, then answer
		acc = apb_req.psel & apb_req.penable;
		first = acc & ~s_r.rsp.pready;
		done = acc & s_r.rsp.pready;
		mapped = hit(apb_req.paddr, PDME_RX_IDX) | hit(apb_req.paddr, PDME_TX_IDX)
			| hit(apb_req.paddr, PDME_STAT_IDX) | hit(apb_req.paddr, PDME_CLR_IDX)
			| hit(apb_req.paddr, PDME_EN_IDX);
		rd_val = '0;
		if (hit(apb_req.paddr, PDME_RX_IDX)) begin
			rd_val[PDME_B_DC_EN] = s_r.rx_dc_en;
			rd_val[PDME_B_ZR_EN] = s_r.rx_zr_en;
			rd_val[PDME_B_DC_FLAG] = s_r.rx_dc_flag;
			rd_val[PDME_B_ZR_FLAG] = s_r.rx_zr_flag;
			rd_val[PDME_B_DV] = s_r.rx_dv;
		end else if (hit(apb_req.paddr, PDME_TX_IDX)) begin
			rd_val[PDME_B_DC_EN] = s_r.tx_dc_en;
			rd_val[PDME_B_ZR_EN] = s_r.tx_zr_en;
			rd_val[PDME_B_DC_FLAG] = s_r.tx_dc_flag;
			rd_val[PDME_B_ZR_FLAG] = s_r.tx_zr_flag;
			rd_val[PDME_B_DV] = s_r.tx_dv;
			rd_val[PDME_B_FILL_FLAG] = s_r.fill_flag;
			rd_val[PDME_B_FILL_EN] = s_r.fill_en;
			rd_val[PDME_B_FILL_IRQ_EN] = s_r.fill_irq_en;
		end else if (hit(apb_req.paddr, PDME_STAT_IDX)) begin
			rd_val[PDME_S_RX_DC] = s_r.rx_dc_flag;
			rd_val[PDME_S_RX_ZR] = s_r.rx_zr_flag;
			rd_val[PDME_S_TX_DC] = s_r.tx_dc_flag;
			rd_val[PDME_S_TX_ZR] = s_r.tx_zr_flag;
			rd_val[PDME_S_FILL] = s_r.fill_flag;
		end else if (hit(apb_req.paddr, PDME_EN_IDX)) begin
			rd_val[PDME_S_RX_DC] = s_r.rx_dc_en;
			rd_val[PDME_S_RX_ZR] = s_r.rx_zr_en;
			rd_val[PDME_S_TX_DC] = s_r.tx_dc_en;
			rd_val[PDME_S_TX_ZR] = s_r.tx_zr_en;
			rd_val[PDME_S_FILL] = s_r.fill_irq_en;
		end
		s_nxt.rsp.pready = first;
		s_nxt.rsp.pslverr = first & ~mapped;
		s_nxt.rsp.prdata = (first & ~apb_req.pwrite) ? rd_val : '0;
		// Writes take effect at the completing edge
		wd = apb_req.pwdata;
		clr_rx_dc = 1'b0;
		clr_rx_zr = 1'b0;
		clr_tx_dc = 1'b0;
		clr_tx_zr = 1'b0;
		clr_fill = 1'b0;
		if (done && apb_req.pwrite) begin
			if (hit(apb_req.paddr, PDME_RX_IDX)) begin
				s_nxt.rx_dc_en = wd[PDME_B_DC_EN];
				s_nxt.rx_zr_en = wd[PDME_B_ZR_EN];
			end else if (hit(apb_req.paddr, PDME_TX_IDX)) begin
				s_nxt.tx_dc_en = wd[PDME_B_DC_EN];
				s_nxt.tx_zr_en = wd[PDME_B_ZR_EN];
				s_nxt.fill_en = wd[PDME_B_FILL_EN];
				s_nxt.fill_irq_en = wd[PDME_B_FILL_IRQ_EN];
			end else if (hit(apb_req.paddr, PDME_EN_IDX)) begin
				s_nxt.rx_dc_en = wd[PDME_S_RX_DC];
				s_nxt.rx_zr_en = wd[PDME_S_RX_ZR];
				s_nxt.tx_dc_en = wd[PDME_S_TX_DC];
				s_nxt.tx_zr_en = wd[PDME_S_TX_ZR];
				s_nxt.fill_irq_en = wd[PDME_S_FILL];
			end else if (hit(apb_req.paddr, PDME_CLR_IDX)) begin
				// Write one to clear
				clr_rx_dc = wd[PDME_S_RX_DC];
				clr_rx_zr = wd[PDME_S_RX_ZR];
				clr_tx_dc = wd[PDME_S_TX_DC];
				clr_tx_zr = wd[PDME_S_TX_ZR];
				clr_fill = wd[PDME_S_FILL];
			end
		end else if (done) begin
			// Read clears only what the answer showed
			if (hit(apb_req.paddr, PDME_RX_IDX)) begin
				clr_rx_dc = s_r.rsp.prdata[PDME_B_DC_FLAG]; // see (R3)
				clr_rx_zr = s_r.rsp.prdata[PDME_B_ZR_FLAG]; // see (R4)
			end else if (hit(apb_req.paddr, PDME_TX_IDX)) begin
				clr_tx_dc = s_r.rsp.prdata[PDME_B_DC_FLAG];
				clr_tx_zr = s_r.rsp.prdata[PDME_B_ZR_FLAG];
				clr_fill = s_r.rsp.prdata[PDME_B_FILL_FLAG]; // see (R10)
			end
		end
		// Sticky flags: set wins over clear, irq enables not consulted
		s_nxt.rx_dc_flag = (s_r.rx_dc_flag & ~clr_rx_dc) | rx_dc_evt; // see (R3) (R5)
		s_nxt.rx_zr_flag = (s_r.rx_zr_flag & ~clr_rx_zr) | rx_zr_evt; // see (R4) (R5)
		s_nxt.tx_dc_flag = (s_r.tx_dc_flag & ~clr_tx_dc) | tx_dc_evt;
		s_nxt.tx_zr_flag = (s_r.tx_zr_flag & ~clr_tx_zr) | tx_zr_evt;
		s_nxt.fill_flag = (s_r.fill_flag & ~clr_fill) | fill_evt; // see (R10)
		if (s_nxt.fill_en) begin
			s_nxt.tx_dc_flag = 1'b0; // see (R12)
			s_nxt.tx_zr_flag = 1'b0; // see (R12)
		end
		// Interrupt from enabled flags of the next state
		irq = (s_nxt.rx_dc_flag & s_nxt.rx_dc_en) // see (R1)
			| (s_nxt.rx_zr_flag & s_nxt.rx_zr_en) // see (R2)
			| (s_nxt.tx_dc_flag & s_nxt.tx_dc_en & ~s_nxt.fill_irq_en) // see (R13)
			| (s_nxt.tx_zr_flag & s_nxt.tx_zr_en)
			| (s_nxt.fill_flag & s_nxt.fill_irq_en); // see (R11)
		s_nxt.irq_n = ~irq; // see (R15)
	end

	// State register; history starts full of ones
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0; // see (R14)
			s_r.rx_hist <= '1;
			s_r.tx_hist <= '1;
			s_r.rx_dc_en <= PDME_EN_RST;
			s_r.fill_en <= PDME_EN_RST;
			s_r.fill_irq_en <= PDME_EN_RST;
			s_r.irq_n <= PDME_IRQ_N_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign apb_rsp = s_r.rsp;
	assign tx_out = s_r.tx_out;
	assign irq_n_out = s_r.irq_n;

	// Receive change sets its flag at once
	rx_dc_set_a: assert property (@(posedge clk) disable iff (rst) // see (R3)
		$changed(s_r.rx_dv) |-> s_r.rx_dc_flag)
		else $error("density change flag not set");

	// Sixteenth zero sets the zero-run flag
	rx_zr_set_a: assert property (@(posedge clk) disable iff (rst) // see (R4)
		s_r.rx_zrun == PDME_ZRUN_LEN && $past(s_r.rx_zrun) != PDME_ZRUN_LEN |-> s_r.rx_zr_flag)
		else $error("zero run flag not set");

	// Sixteen zeros always count as violation
	zrun_viol_a: assert property (@(posedge clk) disable iff (rst) // see (R16)
		s_r.rx_zrun == PDME_ZRUN_LEN |-> s_r.rx_dv)
		else $error("zero run not a violation");

	// Filling keeps live bit and flags low
	fill_quiet_a: assert property (@(posedge clk) disable iff (rst) // see (R12)
		s_r.fill_en && $past(s_r.fill_en) |-> !s_r.tx_dv && !s_r.tx_dc_flag && !s_r.tx_zr_flag)
		else $error("transmit status not held low");

	// Passthrough copies data after one cycle
	pass_data_a: assert property (@(posedge clk) disable iff (rst) // see (R9)
		!s_r.fill_en && tx_in.strobe |=> tx_out.strobe && tx_out.bit_val == $past(tx_in.bit_val))
		else $error("passthrough altered data");

	// A forced one is always flagged
	fill_mark_a: assert property (@(posedge clk) disable iff (rst) // see (R10)
		tx_out.strobe && tx_out.bit_val && !$past(tx_in.bit_val) |-> s_r.fill_flag)
		else $error("insertion not flagged");

	// Enabled flag drives the interrupt low
	irq_drive_a: assert property (@(posedge clk) disable iff (rst) // see (R15)
		(s_r.rx_dc_flag && s_r.rx_dc_en) || (s_r.fill_flag && s_r.fill_irq_en) |-> !irq_n_out)
		else $error("interrupt not asserted");

	// Fill irq enable masks transmit density irq
	irq_mask_a: assert property (@(posedge clk) disable iff (rst) // see (R13)
		s_r.fill_irq_en && !s_r.fill_flag && !s_r.rx_dc_flag && !s_r.rx_zr_flag && !s_r.tx_zr_flag
		|-> irq_n_out)
		else $error("masked interrupt asserted");

	// Read clears a shown flag unless a new change
	rd_clear_a: assert property (@(posedge clk) disable iff (rst) // see (R3)
		apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite
		&& hit(apb_req.paddr, PDME_RX_IDX) && apb_rsp.prdata[PDME_B_DC_FLAG]
		|=> !s_r.rx_dc_flag || $changed(s_r.rx_dv))
		else $error("read did not clear flag");

	// Enables are zero after reset
	reset_en_a: assert property (@(posedge clk) // see (R14)
		$past(rst) && !rst |-> !s_r.fill_en && !s_r.fill_irq_en && !s_r.rx_dc_en && !s_r.tx_zr_en)
		else $error("enable not reset");

	// Bus answers after exactly one wait
	apb_wait_a: assert property (@(posedge clk) disable iff (rst)
		apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
		else $error("bus answer late");

	// Passthrough sixteenth zero sets the transmit flag
	tx_zr_set_a: assert property (@(posedge clk) disable iff (rst) // see (R9)
		!s_r.fill_en && !$past(s_r.fill_en) && s_r.tx_zrun == PDME_ZRUN_LEN
		&& $past(s_r.tx_zrun) != PDME_ZRUN_LEN |-> s_r.tx_zr_flag)
		else $error("transmit zero run flag not set");

	// Passthrough density change sets the transmit flag
	tx_dc_set_a: assert property (@(posedge clk) disable iff (rst) // see (R9)
		!s_r.fill_en && !$past(s_r.fill_en) && $changed(s_r.tx_dv) |-> s_r.tx_dc_flag)
		else $error("transmit density flag not set");
endmodule

// file: testbench/pdme_bit_src.sv
`timescale 1ns/1ns
// Framer side bit source feeding one serial input
module pdme_bit_src import pdme_pkg::*; (
	output pdme_bit_t bit_out,
	input wire logic clk
);
	// Idle line, no strobe
	initial bit_out = '0;
	// Sends n bits LSB first with gap idle cycles after each strobe
	task automatic send(input logic [31:0] pat, input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			bit_out <= '{bit_val: pat[i], strobe: 1'b1};
			// Between strobes the data line shows the inverse, never the held bit
			for (int g = 0; g < gap; g++) begin
				@(posedge clk);
				bit_out <= '{bit_val: ~pat[i], strobe: 1'b0};
			end
		end
		@(posedge clk);
		bit_out <= '{bit_val: ~pat[n-1], strobe: 1'b0};
	endtask
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top import pdme_pkg::*; ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	pdme_apb_req_t req = '0; // Bus request
	pdme_apb_rsp_t rsp;
	pdme_bit_t rx_b;
	pdme_bit_t tx_b;
	pdme_bit_t tx_o;
	logic irq_n;
	int fails = 0;
	int n_tests = 0;
	logic fmode = 1'b0; // Fill active, exact compare off
	logic ps = 1'b0; // Strobe of the previous cycle
	logic pv = 1'b0; // Bit of the previous cycle
	int zrun = 0; // Zero run on the transmit output
	// Clock of 20 ns
	initial forever #10 clk = ~clk;
	// Small density window to keep runs short
	pdme_top #(.MAX_N(3)) dut (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .rx_in(rx_b),
		.tx_in(tx_b), .tx_out(tx_o), .irq_n_out(irq_n));
	pdme_bit_src rx_src (.bit_out(rx_b), .clk(clk));
	pdme_bit_src tx_src (.bit_out(tx_b), .clk(clk));
	// Counts a compare, reports a mismatch
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Prints the counts and the verdict
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// One APB transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd, output logic [31:0] r,
		output logic er);
		int k;
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: {24'h00_0000, wd}};
		@(posedge clk);
		req.penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (rsp.pready === 1'b1) begin
				break;
			end
		end
		r = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		if (k == 20) begin
			fails++;
			test_done();
		end
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, idx, d, r, e);
	endtask
	// Read and compare the whole word against the byte zero-extended, no error expected
	task automatic rd(input string nm, input logic [9:0] idx, input logic [7:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, idx, 8'h00, r, e);
		chk(nm, {24'h00_0000, x}, r);
		chk({nm, " err"}, 32'h0000_0000, {31'h0, e});
	endtask
	// Interrupt level once the last edge has landed
	task automatic irq_is(input string nm, input logic x);
		@(negedge clk);
		chk(nm, {31'h0, x}, {31'h0, irq_n});
	endtask
	// Transmit output against the input one cycle before
	always @(posedge clk) begin
		if (ps === 1'b1) begin
			chk("tx strobe", 32'h0000_0001, {31'h0, tx_o.strobe});
			if (fmode === 1'b0) begin
				chk("tx pass", {31'h0, pv}, {31'h0, tx_o.bit_val});
			end else if (pv === 1'b1) begin
				chk("tx fill keeps one", 32'h0000_0001, {31'h0, tx_o.bit_val});
			end
		end
		if (tx_o.strobe === 1'b1) begin
			zrun = (tx_o.bit_val === 1'b0) ? zrun + 1 : 0;
			chk("tx fill run", 32'h0000_0000, {31'h0, fmode === 1'b1 && zrun >= 16});
		end
		ps <= tx_b.strobe;
		pv <= tx_b.bit_val;
	end
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		irq_is("irq reset", 1'b1);
		rd("rx reset", PDME_RX_IDX, 8'h00);
		rd("tx reset", PDME_TX_IDX, 8'h00);
		apb(1'b0, 10'h100, 8'h00, r, e);
		chk("unmapped data", 32'h0000_0000, r);
		chk("unmapped err", 32'h0000_0001, {31'h0, e});
	endtask
	// Window breach without a sixteen zero run
	task automatic t_rx_dens();
		rx_src.send(32'hFFFF_FFFF, 32, 0);
		rx_src.send(32'h0000_8000, 24, 1);
		rd("rx window", PDME_RX_IDX, 8'h14);
		irq_is("irq no enable", 1'b1);
		rx_src.send(32'h0000_00FF, 8, 2);
		rd("rx dc end", PDME_RX_IDX, 8'h04);
		rd("rx cleared", PDME_RX_IDX, 8'h00);
	endtask
	task automatic t_rx_zero();
		wr(PDME_RX_IDX, 8'h02);
		rx_src.send(32'h0000_0000, 16, 0);
		irq_is("irq zero run", 1'b0);
		rd("rx zero run", PDME_RX_IDX, 8'h1E);
		irq_is("irq release", 1'b1);
		rx_src.send(32'hFFFF_FFFF, 8, 0);
		irq_is("irq dc off", 1'b1);
		rd("rx dc off", PDME_RX_IDX, 8'h06);
		wr(PDME_RX_IDX, 8'h01);
		rx_src.send(32'h0000_0000, 16, 1);
		irq_is("irq dc start", 1'b0);
		rd("rx dc start", PDME_RX_IDX, 8'h1D);
		irq_is("irq cleared", 1'b1);
		rx_src.send(32'hFFFF_FFFF, 8, 0);
		irq_is("irq dc stop", 1'b0);
		rd("rx dc stop", PDME_RX_IDX, 8'h05);
		wr(PDME_RX_IDX, 8'h00);
	endtask
	// Pass through, then filling with and without its interrupt
	task automatic t_tx();
		wr(PDME_TX_IDX, 8'h81);
		tx_src.send(32'h0000_0000, 16, 0);
		irq_is("tx dc masked", 1'b1);
		rd("tx pass flags", PDME_TX_IDX, 8'h9D);
		tx_src.send(32'hFFFF_FFFF, 8, 0);
		rd("tx dc end", PDME_TX_IDX, 8'h85);
		fmode = 1'b1;
		wr(PDME_TX_IDX, 8'hC1);
		tx_src.send(32'h0000_0000, 20, 0);
		irq_is("irq fill", 1'b0);
		rd("tx fill", PDME_TX_IDX, 8'hE1);
		irq_is("irq fill clr", 1'b1);
		wr(PDME_TX_IDX, 8'h41);
		tx_src.send(32'h0000_0000, 20, 1);
		irq_is("irq fill off", 1'b1);
		rd("tx fill noirq", PDME_TX_IDX, 8'h61);
		wr(PDME_TX_IDX, 8'h00);
		fmode = 1'b0;
	endtask
	// Summary, clear and enable registers, then a reset in mid-run
	task automatic t_own();
		wr(PDME_EN_IDX, 8'h1F);
		rd("en alias", PDME_EN_IDX, 8'h1F);
		rd("tx en alias", PDME_TX_IDX, 8'h83);
		wr(PDME_EN_IDX, 8'h08);
		tx_src.send(32'h0000_0000, 16, 0);
		irq_is("irq tx zero run", 1'b0);
		rd("stat no clear", PDME_STAT_IDX, 8'h0C);
		irq_is("irq after stat", 1'b0);
		wr(PDME_CLR_IDX, 8'h08);
		irq_is("irq after clr", 1'b1);
		rd("stat after clr", PDME_STAT_IDX, 8'h04);
		rd("clr reads zero", PDME_CLR_IDX, 8'h00);
		wr(PDME_CLR_IDX, 8'h04);
		rd("stat cleared", PDME_STAT_IDX, 8'h00);
		wr(PDME_TX_IDX, 8'hC3);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		irq_is("irq mid reset", 1'b1);
		rd("tx mid reset", PDME_TX_IDX, 8'h00);
		rd("en mid reset", PDME_EN_IDX, 8'h00);
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_rx_dens();
		t_rx_zero();
		t_tx();
		t_own();
		test_done();
	end
endmodule
